//--- src/iosf_map.vh
// Purpose: Byte codes, offsets and field positions of the input sample framer
// Assumes: Included by the framer and its FIFO only
// Notes:   Definitions only
`ifndef IOSF_MAP_VH
`define IOSF_MAP_VH

// ----------------------------------------------------------------------------
// Frame codes
// ----------------------------------------------------------------------------
`define IOSF_START_DELIM 8'h7E
`define IOSF_TYPE_SAMPLE 8'h92
`define IOSF_TYPE_EXPLICIT 8'h91
`define IOSF_CSUM_BASE 8'hFF

// ----------------------------------------------------------------------------
// Byte offsets inside a frame
// ----------------------------------------------------------------------------
`define IOSF_OFS_LEN_HI 6'h01
`define IOSF_OFS_LEN_LO 6'h02
`define IOSF_OFS_TYPE 6'h03
`define IOSF_OFS_IEEE 6'h04
`define IOSF_OFS_NWK 6'h0C
`define IOSF_OFS_SMP_OPTS 6'h0E
`define IOSF_OFS_SMP_COUNT 6'h0F
`define IOSF_OFS_DMASK 6'h10
`define IOSF_OFS_AMASK 6'h12
`define IOSF_OFS_DSAMPLES 6'h13
`define IOSF_OFS_SRC_EP 6'h0E
`define IOSF_OFS_DST_EP 6'h0F
`define IOSF_OFS_CLUSTER 6'h10
`define IOSF_OFS_PROFILE 6'h12
`define IOSF_OFS_EXP_OPTS 6'h14
`define IOSF_OFS_EXP_DATA 6'h15

// ----------------------------------------------------------------------------
// Length bases: bytes from frame type through last fixed field
// ----------------------------------------------------------------------------
`define IOSF_SMP_LEN_BASE 16'h0010
`define IOSF_EXP_LEN_BASE 16'h0012
`define IOSF_DSAMPLE_LEN 16'h0002

// ----------------------------------------------------------------------------
// Field layouts
// ----------------------------------------------------------------------------
`define IOSF_OPT_ACKED 8'h01
`define IOSF_OPT_BCAST 8'h02
`define IOSF_DMASK_VALID 16'h7FFF
`define IOSF_AMASK_SUPPLY_BIT 7
`define IOSF_AO_EXPLICIT_BIT 0
`define IOSF_TAIL_LAST_SLOT 3'h5
`define IOSF_FIFO_WIDTH 8
`define IOSF_FIFO_DEPTH 16

`endif

//--- src/iosf_fifo.v
// Purpose: Byte FIFO between the framer and the serial port
// Assumes: One clock, asynchronous active-low reset
// Notes:   Depth must be a power of two
`timescale 1ns/1ps
`include "iosf_map.vh"

module iosf_fifo #(
  parameter WIDTH = `IOSF_FIFO_WIDTH,
  parameter DEPTH = `IOSF_FIFO_DEPTH,
  parameter AW = 4
) (
  input wire mclk,
  input wire rstn,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;

  // Honest full and empty from the fill count
  assign in_ready = (count_q != DEPTH[AW:0]);
  assign out_valid = (count_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_ptr_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage, no reset needed on data
  always @(posedge mclk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // Pointers and fill count
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule // iosf_fifo

//--- src/iosf_framer.v
// Purpose: Builds sample and explicit receive frames for the serial host port
// Assumes: Request, payload and config inputs come from logic on mclk
// Notes:   Output bytes pass a 16-byte FIFO; the host stalls it with ser_ready
// Function
// - Every frame starts with the one-byte start delimiter at offset 0.
// - Offsets 1-2 hold length of bytes between length field and checksum.
// - Sample frames use frame type 0x92 at offset 3.
// - Sample frames go out only in API mode; dropped otherwise.
// - Sender IEEE address at offsets 4-11, network address at 12-13.
// - Receive options byte at 14: 0x01 acknowledged, 0x02 broadcast, combinable.
// - Offset 15 carries the count of sample sets, normally one.
// - Digital mask at 16 flags lines 0-14; bit 15 always zero.
// - Analog mask at 18: inputs 0-3 in bits 0-3, supply in bit 7.
// - Digital samples word at 19 only when digital mask is nonzero.
// - Digital samples share mask bit positions; unsampled lines read zero.
// - One 16-bit result per enabled analog input, input 0 first.
// - Last byte is 0xFF minus low byte of sum from offset 3 on.
// - Explicit frame payload passes as received, little-endian; header big-endian.
// - Explicit frame 0x91: endpoints 14,15, cluster 16, profile 18, options 20.
`timescale 1ns/1ps
`include "iosf_map.vh"

module iosf_framer #(
  parameter FIFO_DEPTH = `IOSF_FIFO_DEPTH,
  parameter FIFO_AW = 4
) (
  input wire mclk,
  input wire rstn,
  input wire api_mode,
  input wire [7:0] api_output_option,
  input wire supply_monitor_en,
  input wire smp_valid,
  output wire smp_ready,
  input wire [7:0] smp_count,
  input wire [15:0] smp_dmask,
  input wire [3:0] smp_amask,
  input wire [15:0] smp_dsamples,
  input wire [63:0] smp_analog,
  input wire [15:0] smp_supply,
  input wire exp_valid,
  output wire exp_ready,
  input wire [7:0] exp_src_ep,
  input wire [7:0] exp_dst_ep,
  input wire [15:0] exp_cluster,
  input wire [15:0] exp_profile,
  input wire [15:0] exp_data_len,
  input wire [63:0] src_ieee_addr,
  input wire [15:0] src_nwk_addr,
  input wire src_acked,
  input wire src_bcast,
  input wire pl_valid,
  output wire pl_ready,
  input wire [7:0] pl_data,
  output wire ser_valid,
  input wire ser_ready,
  output wire [7:0] ser_data,
  output wire busy,
  output wire drop_pulse
);

  // --------------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------------
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_HEAD = 5'h02;
  localparam [4:0] ST_TAIL = 5'h04;
  localparam [4:0] ST_PAYL = 5'h08;
  localparam [4:0] ST_CSUM = 5'h10;

  reg [4:0] state_q;
  reg [4:0] state_d;
  reg [5:0] idx_q;
  reg [2:0] slot_q;
  reg half_q;
  reg [15:0] left_q;
  reg [7:0] sum_q;
  reg drop_q;
  reg kind_exp_q;
  reg [15:0] len_q;
  reg [63:0] ieee_q;
  reg [15:0] nwk_q;
  reg [7:0] opts_q;
  reg [7:0] cnt_q;
  reg [15:0] dmask_q;
  reg [7:0] amask_q;
  reg [15:0] dsmp_q;
  reg [79:0] ana_q;
  reg [7:0] sep_q;
  reg [7:0] dep_q;
  reg [15:0] clus_q;
  reg [15:0] prof_q;

  reg [7:0] byte_d;
  reg [15:0] word_d;
  reg present_d;
  reg push_d;
  reg [5:0] head_last_d;
  reg [2:0] ana_n_d;
  reg [15:0] len_d;

  wire fifo_in_ready;
  wire idle;
  wire take_smp;
  wire take_exp;
  wire [15:0] dmask_clean;
  wire [7:0] amask_full;
  wire [7:0] opts_in;

  assign idle = state_q[0];
  assign smp_ready = idle;
  assign exp_ready = idle & ~smp_valid;
  assign take_smp = idle & smp_valid;
  assign take_exp = idle & exp_valid & ~smp_valid;
  assign busy = ~idle;
  assign drop_pulse = drop_q;
  assign pl_ready = state_q[3] & fifo_in_ready & (left_q != 16'h0000);

  // Incoming field shaping
  assign dmask_clean = smp_dmask & `IOSF_DMASK_VALID;
  assign amask_full = {supply_monitor_en, 3'h0, smp_amask};
  assign opts_in = (src_acked ? `IOSF_OPT_ACKED : 8'h00) | (src_bcast ? `IOSF_OPT_BCAST : 8'h00);

  // --------------------------------------------------------------------------
  // Length of the request being taken
  // --------------------------------------------------------------------------
  always @* begin
    ana_n_d = {2'b00, amask_full[0]} + {2'b00, amask_full[1]} + {2'b00, amask_full[2]}
            + {2'b00, amask_full[3]} + {2'b00, amask_full[`IOSF_AMASK_SUPPLY_BIT]};
    // Count each field that will really be sent
    if (smp_valid) begin
      len_d = `IOSF_SMP_LEN_BASE + {11'h000, ana_n_d, 2'b00} / 16'h0002
            + ((dmask_clean != 16'h0000) ? `IOSF_DSAMPLE_LEN : 16'h0000);
    end else begin
      len_d = `IOSF_EXP_LEN_BASE + exp_data_len;
    end
  end

  // --------------------------------------------------------------------------
  // Byte selection
  // --------------------------------------------------------------------------
  always @* begin
    head_last_d = kind_exp_q ? `IOSF_OFS_EXP_OPTS : `IOSF_OFS_AMASK;
    // Tail slots: 0 digital word, 1-4 analog inputs 0-3, 5 supply
    case (slot_q)
      3'h0: begin
        present_d = (dmask_q != 16'h0000);
        word_d = dsmp_q & dmask_q;
      end
      3'h1: begin
        present_d = amask_q[0];
        word_d = ana_q[15:0];
      end
      3'h2: begin
        present_d = amask_q[1];
        word_d = ana_q[31:16];
      end
      3'h3: begin
        present_d = amask_q[2];
        word_d = ana_q[47:32];
      end
      3'h4: begin
        present_d = amask_q[3];
        word_d = ana_q[63:48];
      end
      3'h5: begin
        present_d = amask_q[`IOSF_AMASK_SUPPLY_BIT];
        word_d = ana_q[79:64];
      end
      default: begin
        present_d = 1'b0;
        word_d = 16'h0000;
      end
    endcase
    byte_d = 8'h00;
    push_d = 1'b0;
    case (state_q)
      ST_HEAD: begin
        push_d = 1'b1;
        if (idx_q == 6'h00) begin
          byte_d = `IOSF_START_DELIM;
        end else if (idx_q == `IOSF_OFS_LEN_HI) begin
          byte_d = len_q[15:8];
        end else if (idx_q == `IOSF_OFS_LEN_LO) begin
          byte_d = len_q[7:0];
        end else if (idx_q == `IOSF_OFS_TYPE) begin
          byte_d = kind_exp_q ? `IOSF_TYPE_EXPLICIT : `IOSF_TYPE_SAMPLE;
        end else if (idx_q < `IOSF_OFS_NWK) begin
          // Big-endian IEEE address, most significant byte first
          byte_d = ieee_q[8'h3F - {idx_q[2:0] - 3'h4, 3'b000} -: 8];
        end else if (idx_q == `IOSF_OFS_NWK) begin
          byte_d = nwk_q[15:8];
        end else if (idx_q == `IOSF_OFS_NWK + 6'h01) begin
          byte_d = nwk_q[7:0];
        end else if (kind_exp_q) begin
          // Explicit header fields, big-endian
          case (idx_q)
            `IOSF_OFS_SRC_EP: byte_d = sep_q;
            `IOSF_OFS_DST_EP: byte_d = dep_q;
            `IOSF_OFS_CLUSTER: byte_d = clus_q[15:8];
            `IOSF_OFS_CLUSTER + 6'h01: byte_d = clus_q[7:0];
            `IOSF_OFS_PROFILE: byte_d = prof_q[15:8];
            `IOSF_OFS_PROFILE + 6'h01: byte_d = prof_q[7:0];
            `IOSF_OFS_EXP_OPTS: byte_d = opts_q;
            default: byte_d = 8'h00;
          endcase
        end else begin
          case (idx_q)
            `IOSF_OFS_SMP_OPTS: byte_d = opts_q;
            `IOSF_OFS_SMP_COUNT: byte_d = cnt_q;
            `IOSF_OFS_DMASK: byte_d = dmask_q[15:8];
            `IOSF_OFS_DMASK + 6'h01: byte_d = dmask_q[7:0];
            `IOSF_OFS_AMASK: byte_d = amask_q;
            default: byte_d = 8'h00;
          endcase
        end
      end
      ST_TAIL: begin
        push_d = present_d;
        byte_d = half_q ? word_d[7:0] : word_d[15:8];
      end
      ST_PAYL: begin
        // Payload bytes pass in arrival order, so little-endian fields stay so
        push_d = pl_valid & (left_q != 16'h0000);
        byte_d = pl_data;
      end
      ST_CSUM: begin
        push_d = 1'b1;
        byte_d = `IOSF_CSUM_BASE - sum_q;
      end
      default: begin
        push_d = 1'b0;
        byte_d = 8'h00;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        // Sample frames need API mode, explicit ones need the option bit
        if (take_smp && api_mode) begin
          state_d = ST_HEAD;
        end else if (take_exp && api_mode && api_output_option[`IOSF_AO_EXPLICIT_BIT]) begin
          state_d = ST_HEAD;
        end
      end
      ST_HEAD: begin
        if (fifo_in_ready && idx_q == head_last_d) begin
          state_d = kind_exp_q ? ST_PAYL : ST_TAIL;
        end
      end
      ST_TAIL: begin
        if (slot_q == `IOSF_TAIL_LAST_SLOT && (!present_d || (half_q && fifo_in_ready))) begin
          state_d = ST_CSUM;
        end
      end
      ST_PAYL: begin
        if (left_q == 16'h0000) begin
          state_d = ST_CSUM;
        end
      end
      ST_CSUM: begin
        if (fifo_in_ready) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Sequencer and checksum
  // --------------------------------------------------------------------------
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      idx_q <= 6'h00;
      slot_q <= 3'h0;
      half_q <= 1'b0;
      left_q <= 16'h0000;
      sum_q <= 8'h00;
      drop_q <= 1'b0;
    end else begin
      state_q <= state_d;
      drop_q <= (take_smp & ~api_mode)
              | (take_exp & ~(api_mode & api_output_option[`IOSF_AO_EXPLICIT_BIT]));
      if (idle) begin
        idx_q <= 6'h00;
        slot_q <= 3'h0;
        half_q <= 1'b0;
        sum_q <= 8'h00;
        left_q <= exp_data_len;
      end else begin
        // Sum runs from the frame type byte onward
        if (push_d && fifo_in_ready && !state_q[4] && !(state_q[1] && idx_q < `IOSF_OFS_TYPE)) begin
          sum_q <= sum_q + byte_d;
        end
        if (state_q[1] && fifo_in_ready) begin
          idx_q <= idx_q + 6'h01;
        end
        // Absent slots are skipped without a byte
        if (state_q[2]) begin
          if (!present_d) begin
            slot_q <= slot_q + 3'h1;
          end else if (fifo_in_ready) begin
            half_q <= ~half_q;
            if (half_q) begin
              slot_q <= slot_q + 3'h1;
            end
          end
        end
        if (state_q[3] && pl_valid && pl_ready) begin
          left_q <= left_q - 16'h0001;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Request capture
  // --------------------------------------------------------------------------
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      kind_exp_q <= 1'b0;
      len_q <= 16'h0000;
      ieee_q <= 64'h0000000000000000;
      nwk_q <= 16'h0000;
      opts_q <= 8'h00;
      cnt_q <= 8'h00;
      dmask_q <= 16'h0000;
      amask_q <= 8'h00;
      dsmp_q <= 16'h0000;
      ana_q <= 80'h00000000000000000000;
      sep_q <= 8'h00;
      dep_q <= 8'h00;
      clus_q <= 16'h0000;
      prof_q <= 16'h0000;
    end else if (take_smp || take_exp) begin
      kind_exp_q <= take_exp;
      len_q <= len_d;
      ieee_q <= src_ieee_addr;
      nwk_q <= src_nwk_addr;
      opts_q <= opts_in;
      cnt_q <= smp_count;
      dmask_q <= dmask_clean;
      amask_q <= amask_full;
      dsmp_q <= smp_dsamples;
      ana_q <= {smp_supply, smp_analog};
      sep_q <= exp_src_ep;
      dep_q <= exp_dst_ep;
      clus_q <= exp_cluster;
      prof_q <= exp_profile;
    end
  end

  // --------------------------------------------------------------------------
  // Output FIFO
  // --------------------------------------------------------------------------
  iosf_fifo #(
    .WIDTH(`IOSF_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .rstn(rstn),
    .in_valid(push_d),
    .in_ready(fifo_in_ready),
    .in_data(byte_d),
    .out_valid(ser_valid),
    .out_ready(ser_ready),
    .out_data(ser_data)
  );

endmodule // iosf_framer

//--- verif/iosf_framer_properties.sv
// Purpose: Port assertions for the input sample framer
// Assumes: Bound to iosf_framer, one clock domain
// Notes:   Watches requests, drops and the serial byte stream
`timescale 1ns/1ps
module iosf_framer_chk (
  input wire mclk,
  input wire rstn,
  input wire api_mode,
  input wire [7:0] api_output_option,
  input wire smp_valid,
  input wire smp_ready,
  input wire exp_valid,
  input wire exp_ready,
  input wire ser_valid,
  input wire ser_ready,
  input wire [7:0] ser_data,
  input wire busy,
  input wire drop_pulse
);
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // No request is taken or dropped while a frame is built
  busy_blocks_ready_a: assert property (busy |-> !smp_ready && !exp_ready && !drop_pulse)
    else $error("ready high during a frame");
  // Sample taken in API mode starts a frame
  sample_starts_a: assert property (smp_valid && smp_ready && api_mode |=> busy)
    else $error("sample frame not started");
  // Sample taken outside API mode is dropped
  sample_dropped_a: assert property (smp_valid && smp_ready && !api_mode |=> drop_pulse && !busy)
    else $error("sample not dropped");
  // Explicit frames need output option bit 0
  explicit_gated_a: assert property (exp_valid && exp_ready && !api_output_option[0] |=> drop_pulse && !busy)
    else $error("explicit frame not dropped");
  // Explicit request with both enables starts a frame
  explicit_starts_a: assert property (exp_valid && exp_ready && api_mode && api_output_option[0] |=> busy)
    else $error("explicit frame not started");
  // Drop indication lasts one cycle
  drop_single_a: assert property (drop_pulse |=> !drop_pulse)
    else $error("drop pulse too long");
  // Offered byte holds until the host takes it
  byte_holds_a: assert property (ser_valid && !ser_ready |=> ser_valid && $stable(ser_data))
    else $error("serial byte changed before taken");
  // Frame on an empty FIFO leads with the delimiter
  delim_first_a: assert property ($rose(busy) && !ser_valid |-> first_match(##[1:2] ser_valid) ##0 ser_data == 8'h7E)
    else $error("frame did not start with delimiter");
  // Frame building ends in bounded time
  frame_ends_a: assert property ($rose(busy) |-> ##[1:600] !busy)
    else $error("frame never ended");

  // Main scenarios reached
  cover property (drop_pulse);
  cover property ($rose(busy));
  cover property (busy && ser_valid && !ser_ready);
endmodule // iosf_framer_chk

bind iosf_framer iosf_framer_chk i_chk (.mclk, .rstn, .api_mode, .api_output_option, .smp_valid, .smp_ready,
  .exp_valid, .exp_ready, .ser_valid, .ser_ready, .ser_data, .busy, .drop_pulse);

//--- verif/iosf_host_model.sv
// Purpose: Host on the serial side of the framer
// Assumes: Mode 0 prompt, 1 every other cycle, 2 held off
// Notes:   Accepted bytes queue up in rx_q for the bench
`timescale 1ns/1ps
module iosf_host_model (
  input wire mclk,
  input wire rstn,
  input wire [1:0] mode,
  input wire ser_valid,
  input wire [7:0] ser_data,
  output logic ser_ready
);
  // ---------------------------------------------------------------------------
  // Pacing and capture
  // ---------------------------------------------------------------------------
  logic [7:0] rx_q[$];
  logic tog_q;

  // Acceptance pace chosen by mode
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ser_ready <= 1'b0;
      tog_q <= 1'b0;
    end else begin
      tog_q <= ~tog_q;
      ser_ready <= (mode == 2'h0) || (mode == 2'h1 && tog_q);
    end
  end

  // Collect every accepted byte for frame checks
  always @(posedge mclk) begin
    if (rstn && ser_valid && ser_ready) begin
      rx_q.push_back(ser_data);
    end
  end
endmodule // iosf_host_model

//--- verif/iosf_framer_tb_top.sv
// Purpose: Self-checking bench for the input sample framer
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Expected frames are built from the bench's own inputs
`timescale 1ns/1ps
module iosf_framer_tb_top;
  // ---------------------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------------------
  logic mclk = 0, rstn = 0, api_mode, supply_monitor_en, smp_valid, exp_valid, src_acked, src_bcast, pl_valid;
  logic [7:0] api_output_option, smp_count, exp_src_ep, exp_dst_ep, pl_data;
  logic [15:0] smp_dmask, smp_dsamples, smp_supply, exp_cluster, exp_profile, exp_data_len, src_nwk_addr;
  logic [3:0] smp_amask;
  logic [63:0] smp_analog, src_ieee_addr;
  logic [1:0] host_mode;
  wire smp_ready, exp_ready, pl_ready, ser_valid, ser_ready, busy, drop_pulse;
  wire [7:0] ser_data;
  int fails = 0, total_checks = 0;
  logic [7:0] exq[$], pay[$], tmp[$];

  iosf_framer i_iosf_framer (.mclk, .rstn, .api_mode, .api_output_option, .supply_monitor_en, .smp_valid,
    .smp_ready, .smp_count, .smp_dmask, .smp_amask, .smp_dsamples, .smp_analog, .smp_supply, .exp_valid,
    .exp_ready, .exp_src_ep, .exp_dst_ep, .exp_cluster, .exp_profile, .exp_data_len, .src_ieee_addr,
    .src_nwk_addr, .src_acked, .src_bcast, .pl_valid, .pl_ready, .pl_data, .ser_valid, .ser_ready,
    .ser_data, .busy, .drop_pulse);
  iosf_host_model i_iosf_host_model (.mclk, .rstn, .mode(host_mode), .ser_valid, .ser_data, .ser_ready);

  // Clock
  always #2 mclk = ~mclk;

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic give_verdict;
    if (fails == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask
  task automatic lim(input int n, input int m);
    if (n >= m) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic w16(input logic [15:0] v);
    exq.push_back(v[15:8]);
    exq.push_back(v[7:0]);
  endtask
  task automatic hdr(input logic [7:0] ftype);
    exq = {8'h7E, 8'h00, 8'h00, ftype};
    for (int i = 7; i >= 0; i--) exq.push_back(src_ieee_addr[i*8 +: 8]);
    w16(src_nwk_addr);
  endtask
  // Length from the bytes present, then checksum
  task automatic seal;
    logic [7:0] s;
    logic [15:0] n;
    s = 8'h00;
    n = 16'(exq.size() - 3);
    exq[1] = n[15:8];
    exq[2] = n[7:0];
    for (int i = 3; i < exq.size(); i++) s += exq[i];
    exq.push_back(8'hFF - s);
  endtask
  task automatic exp_smp;
    logic [15:0] dm;
    dm = smp_dmask & 16'h7FFF;
    hdr(8'h92);
    exq.push_back({6'h00, src_bcast, src_acked});
    exq.push_back(smp_count);
    w16(dm);
    exq.push_back({supply_monitor_en, 3'h0, smp_amask});
    if (dm != 16'h0000) w16(smp_dsamples & dm);
    for (int i = 0; i < 4; i++) if (smp_amask[i]) w16(smp_analog[i*16 +: 16]);
    if (supply_monitor_en) w16(smp_supply);
    seal();
  endtask
  task automatic exp_exp;
    hdr(8'h91);
    exq.push_back(exp_src_ep);
    exq.push_back(exp_dst_ep);
    w16(exp_cluster);
    w16(exp_profile);
    exq.push_back({6'h00, src_bcast, src_acked});
    foreach (pay[i]) exq.push_back(pay[i]);
    seal();
  endtask
  // Raise a request and hold it until taken
  task automatic req(input bit smp);
    int n;
    if (smp) smp_valid = 1;
    else exp_valid = 1;
    for (n = 0; n < 900 && !(smp ? smp_ready : exp_ready); n++) tick;
    lim(n, 900);
    tick;
    smp_valid = 0;
    exp_valid = 0;
  endtask
  task automatic send_pl;
    int n;
    foreach (pay[i]) begin
      pl_valid = 1;
      pl_data = pay[i];
      for (n = 0; n < 100 && !pl_ready; n++) tick;
      lim(n, 100);
      tick;
    end
    pl_valid = 0;
  endtask
  task automatic compare;
    int n;
    for (n = 0; n < 900 && (busy || i_iosf_host_model.rx_q.size() < exq.size()); n++) tick;
    lim(n, 900);
    repeat (3) tick;
    chk(16'(i_iosf_host_model.rx_q.size()), 16'(exq.size()));
    foreach (exq[i]) chk(i_iosf_host_model.rx_q[i], exq[i]);
    i_iosf_host_model.rx_q.delete();
  endtask
  task automatic drop_chk;
    logic seen;
    seen = drop_pulse;
    repeat (3) begin
      tick;
      seen |= drop_pulse;
    end
    chk(seen, 1);
    chk(busy, 0);
    chk(16'(i_iosf_host_model.rx_q.size()), 0);
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {api_mode, supply_monitor_en, smp_valid, exp_valid, src_acked, src_bcast, pl_valid} = '0;
    {api_output_option, smp_count, exp_src_ep, exp_dst_ep, pl_data, smp_amask, host_mode} = '0;
    {smp_dmask, smp_dsamples, smp_supply, exp_cluster, exp_profile, exp_data_len, src_nwk_addr} = '0;
    {smp_analog, src_ieee_addr} = '0;
    repeat (20) @(posedge mclk);
    #1 rstn = 1;
    // Digital word masked, two analog inputs
    api_mode = 1;
    src_ieee_addr = 64'h1122334455667788; // arbitrary
    src_nwk_addr = 16'h87AC;
    src_acked = 1;
    smp_count = 8'h01;
    smp_dmask = 16'h0038;
    smp_dsamples = 16'h002B;
    smp_amask = 4'h6;
    smp_analog = 64'h000000F802250000;
    exp_smp();
    req(1);
    compare();
    // All analog plus supply, host held off then slow
    smp_dmask = 16'h0000;
    smp_amask = 4'hF;
    supply_monitor_en = 1;
    src_bcast = 1;
    smp_count = 8'h02;
    smp_analog = 64'h123456789ABCDEF0;
    smp_supply = 16'h0C40;
    host_mode = 2;
    exp_smp();
    req(1);
    repeat (40) tick;
    chk(busy, 1);
    chk(ser_valid, 1);
    host_mode = 1;
    compare();
    // Back-to-back frames, mask bit 15 cleared
    host_mode = 0;
    smp_dmask = 16'hC001;
    smp_dsamples = 16'hFFFF;
    smp_amask = 4'h0;
    supply_monitor_en = 0;
    exp_smp();
    tmp = exq;
    exq = {tmp, tmp};
    req(1);
    req(1);
    compare();
    // Outside API mode samples are dropped
    api_mode = 0;
    req(1);
    drop_chk();
    // Explicit frame with little-endian payload
    api_mode = 1;
    api_output_option = 8'h01;
    exp_src_ep = 8'h00;
    exp_dst_ep = 8'h00;
    exp_cluster = 16'h8001;
    exp_profile = 16'h0000;
    src_bcast = 0;
    pay = {8'hB5, 8'h00, 8'h88, 8'h77, 8'h66, 8'h55, 8'h44, 8'h33, 8'h22, 8'h11, 8'hAC, 8'h87};
    exp_data_len = 16'd12;
    exp_exp();
    req(0);
    send_pl();
    compare();
    // Option bit 0 clear blocks explicit frames
    api_output_option = 8'h02;
    req(0);
    drop_chk();
    give_verdict();
  end
endmodule // iosf_framer_tb_top
